// ---- pkg/imuf_map.vh ----
/*
 Register map, field positions, reset values and packet slot layout
 for the sensor output format block. Assumes a 32-bit APB slave with
 word-aligned registers: byte address is four times the register index.
*/
`ifndef IMUF_MAP_VH
`define IMUF_MAP_VH

// ***************************************************************
// Register indices (byte address = index * 4)
// ***************************************************************
`define IMUF_IDX_ENA 8'h0C
`define IMUF_IDX_LEN 8'h0E
`define IMUF_IDX_POL 8'h10
`define IMUF_IDX_RNG 8'h12
`define IMUF_IDX_STAT 8'h20
`define IMUF_IDX_LSB 2

// ***************************************************************
// Writable bit masks and reset values
// ***************************************************************
`define IMUF_ENA_MASK 16'hFF07
`define IMUF_LEN_MASK 16'h7F00
`define IMUF_POL_MASK 16'h007E
`define IMUF_RNG_MASK 16'h01FF
`define IMUF_ENA_RST 16'h0000
`define IMUF_LEN_RST 16'h0000
`define IMUF_POL_RST 16'h0000
`define IMUF_RNG_RST 16'h0000

// ***************************************************************
// Field positions
// ***************************************************************
`define IMUF_ITEM_TOP 14
`define IMUF_POL_LSB 1
`define IMUF_POL_W 6
`define IMUF_ACC_RANGE_BIT 8
`define IMUF_DA_MSB 7
`define IMUF_DA_LSB 4
`define IMUF_DV_MSB 3
`define IMUF_DV_LSB 0
`define IMUF_ST_BUSY 0
`define IMUF_ST_RANGE 1
`define IMUF_ST_DA_LSB 4
`define IMUF_ST_DV_LSB 8

// ***************************************************************
// Packet slot layout (slot = one 32-bit sample value)
// ***************************************************************
`define IMUF_SLOT_GYRO 5'd1
`define IMUF_SLOT_ACCL 5'd4
`define IMUF_SLOT_DLTA 5'd7
`define IMUF_SLOT_DLTV 5'd10
`define IMUF_SLOT_QTN 5'd13
`define IMUF_SLOT_ATTI 5'd17
`define IMUF_SLOT_LAST 5'd19
`define IMUF_SLOTS 20

`endif

// ---- src/imuf_pol_inv.v ----
/*
 Per-axis bitwise inversion of angular-rate and acceleration values.
 Assumes axis 0..2 are gyro X,Y,Z and 3..5 accel X,Y,Z, one word each.
*/
module imuf_pol_inv #(
   parameter AXES = 6,
   parameter DW = 32
)(
   input wire [AXES*DW-1:0] raw,
   input wire [AXES-1:0] inv,
   output wire [AXES*DW-1:0] pol
);

   // ************************************************************
   // Invert each axis whose select is set
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < AXES; g = g + 1)
      begin : g_axis
         assign pol[g*DW +: DW] = inv[g] ? ~raw[g*DW +: DW]
                                         : raw[g*DW +: DW];
      end
   endgenerate

endmodule // imuf_pol_inv

// ---- src/imuf_word_sel.v ----
/*
 Picks the 16-bit word to send from one 32-bit sample value.
 Assumes 16-bit items carry their upper half; 32-bit items send
 the upper half first, then the lower half.
*/
module imuf_word_sel (
   input wire [31:0] value,
   input wire len32,
   input wire half,
   output wire [15:0] word
);

   // ************************************************************
   // Upper half unless sending the second word of a long item
   // ************************************************************
   assign word = (len32 && half) ? value[15:0] : value[31:16];

endmodule // imuf_word_sel

// ---- src/imuf_top.v ----
/*
 Output format configuration for a six-axis inertial unit: APB
 registers for word length, axis polarity and range/scale, a per-sample
 snapshot and a 16-bit word stream for burst and streaming packets.
 Assumes a sample strobe from the sensor pipeline on clk_sys and a link
 serialiser that drains words with valid/ready.
*/
`include "imuf_map.vh"

module imuf_top #(
   parameter AW = 12
)(
   input wire clk_sys,
   input wire srst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [AW-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata_q,
   output wire pready,
   output wire pslverr,
   input wire sample_valid,
   output wire sample_ready,
   input wire [31:0] temp_in,
   input wire [95:0] gyro_in,
   input wire [95:0] accel_in,
   input wire [95:0] dlta_in,
   input wire [95:0] dltv_in,
   input wire [127:0] qtn_in,
   input wire [95:0] atti_in,
   output reg [95:0] rate_pol_q,
   output reg [95:0] accel_pol_q,
   output reg accel_range_16g_q,
   output reg [3:0] dlta_shift_q,
   output reg [4:0] dltv_shift_q,
   output reg word_valid_q,
   output reg [15:0] word_data_q,
   input wire word_ready,
   output wire pkt_busy
);

   // ************************************************************
   // Declarations
   // ************************************************************
   localparam ST_IDLE = 1'b0;
   localparam ST_SEND = 1'b1;
   localparam SEL_NONE = 3'd0;
   localparam SEL_ENA = 3'd1;
   localparam SEL_LEN = 3'd2;
   localparam SEL_POL = 3'd3;
   localparam SEL_RNG = 3'd4;
   localparam SEL_STAT = 3'd5;

   reg [15:0] ena_q;
   reg [15:0] len_q;
   reg [15:0] pol_q;
   reg [15:0] rng_q;
   reg [15:0] snap_ena_q;
   reg [15:0] snap_len_q;
   reg [`IMUF_SLOTS*32-1:0] snap_q;
   reg state_q;
   reg [4:0] slot_q;
   reg half_q;
   reg [15:0] rd_word;
   reg [2:0] cur_cls;
   reg cur_en;
   reg cur_len32;
   reg load;
   reg last_word;

   wire [2:0] acc_sel;
   wire wr_stb;
   wire take_sample;
   wire [191:0] pol_out;
   wire [5:0] pol_map;
   wire [`IMUF_SLOTS*32-1:0] sample_flat;
   wire [15:0] cur_word;

   // ************************************************************
   // Address decode, shared by read, write and error paths
   // ************************************************************
   function [2:0] reg_sel;
      input [AW-1:0] addr;
      reg [7:0] idx;
      begin
         idx = addr[`IMUF_IDX_LSB +: 8];
         reg_sel = SEL_NONE;
         if (addr[`IMUF_IDX_LSB-1:0] == 2'b00)
         begin
            case (idx)
               `IMUF_IDX_ENA: reg_sel = SEL_ENA;
               `IMUF_IDX_LEN: reg_sel = SEL_LEN;
               `IMUF_IDX_POL: reg_sel = SEL_POL;
               `IMUF_IDX_RNG: reg_sel = SEL_RNG;
               `IMUF_IDX_STAT: reg_sel = SEL_STAT;
               default: reg_sel = SEL_NONE;
            endcase
         end
      end
   endfunction

   // Slot number to item class (0 temp .. 6 attitude)
   function [2:0] slot_cls;
      input [4:0] slot;
      begin
         if (slot < `IMUF_SLOT_GYRO)
            slot_cls = 3'd0;
         else if (slot < `IMUF_SLOT_ACCL)
            slot_cls = 3'd1;
         else if (slot < `IMUF_SLOT_DLTA)
            slot_cls = 3'd2;
         else if (slot < `IMUF_SLOT_DLTV)
            slot_cls = 3'd3;
         else if (slot < `IMUF_SLOT_QTN)
            slot_cls = 3'd4;
         else if (slot < `IMUF_SLOT_ATTI)
            slot_cls = 3'd5;
         else
            slot_cls = 3'd6;
      end
   endfunction

   // ************************************************************
   // APB slave: zero wait states, error on unmapped address
   // ************************************************************
   assign acc_sel = reg_sel(paddr);
   assign pready = 1'b1;
   assign pslverr = psel && penable && (acc_sel == SEL_NONE);
   assign wr_stb = psel && penable && pwrite;

   // Read mux
   always @*
   begin
      rd_word = 16'h0000;
      case (acc_sel)
         SEL_ENA: rd_word = ena_q;
         SEL_LEN: rd_word = len_q;
         SEL_POL: rd_word = pol_q;
         SEL_RNG: rd_word = rng_q;
         SEL_STAT:
         begin
            rd_word[`IMUF_ST_BUSY] = pkt_busy;
            rd_word[`IMUF_ST_RANGE] = accel_range_16g_q;
            rd_word[`IMUF_ST_DA_LSB +: 4] = dlta_shift_q;
            rd_word[`IMUF_ST_DV_LSB +: 5] = dltv_shift_q;
         end
         default: rd_word = 16'h0000;
      endcase
   end

   // Read data captured in the setup cycle, stable through access
   always @(posedge clk_sys)
   begin
      if (srst)
         prdata_q <= 32'h00000000;
      else if (psel && !penable && !pwrite)
         prdata_q <= {16'h0000, rd_word};
   end

   // Configuration registers, reserved bits held at zero
   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         ena_q <= `IMUF_ENA_RST;
         len_q <= `IMUF_LEN_RST;
         pol_q <= `IMUF_POL_RST;
         rng_q <= `IMUF_RNG_RST;
      end
      else if (wr_stb)
      begin
         case (acc_sel)
            SEL_ENA: ena_q <= pwdata[15:0] & `IMUF_ENA_MASK;
            SEL_LEN: len_q <= pwdata[15:0] & `IMUF_LEN_MASK;
            SEL_POL: pol_q <= pwdata[15:0] & `IMUF_POL_MASK;
            SEL_RNG: rng_q <= pwdata[15:0] & `IMUF_RNG_MASK;
            default: ena_q <= ena_q;
         endcase
      end
   end

   // ************************************************************
   // Polarity inversion of live samples
   // ************************************************************
   // Axis 0 is gyro X at bit 6 down to axis 5, accel Z at bit 1
   genvar a;
   generate
      for (a = 0; a < `IMUF_POL_W; a = a + 1)
      begin : g_polmap
         assign pol_map[a] = pol_q[`IMUF_POL_LSB + `IMUF_POL_W - 1 - a];
      end
   endgenerate

   imuf_pol_inv #(
      .AXES(6),
      .DW(32)
   ) u_pol (
      .raw({accel_in, gyro_in}),
      .inv(pol_map),
      .pol(pol_out)
   );

   // Inverted values and scale selects for delta processing
   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         rate_pol_q <= 96'h0;
         accel_pol_q <= 96'h0;
         accel_range_16g_q <= 1'b0;
         dlta_shift_q <= 4'h0;
         dltv_shift_q <= 5'h00;
      end
      else if (sample_valid)
      begin
         rate_pol_q <= pol_out[95:0];
         accel_pol_q <= pol_out[191:96];
         accel_range_16g_q <= rng_q[`IMUF_ACC_RANGE_BIT];
         dlta_shift_q <= rng_q[`IMUF_DA_MSB:`IMUF_DA_LSB];
         dltv_shift_q <= {1'b0, rng_q[`IMUF_DV_MSB:`IMUF_DV_LSB]}
                       + {4'h0, rng_q[`IMUF_ACC_RANGE_BIT]};
      end
   end

   // ************************************************************
   // Packet snapshot, taken only between packets
   // ************************************************************
   assign sample_flat = {atti_in, qtn_in, dltv_in, dlta_in,
                         pol_out, temp_in};
   assign pkt_busy = (state_q == ST_SEND) || word_valid_q;
   assign sample_ready = !pkt_busy;
   assign take_sample = sample_valid && !pkt_busy;

   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         snap_q <= {`IMUF_SLOTS*32{1'b0}};
         snap_ena_q <= `IMUF_ENA_RST;
         snap_len_q <= `IMUF_LEN_RST;
      end
      else if (take_sample)
      begin
         snap_q <= sample_flat;
         snap_ena_q <= ena_q;
         snap_len_q <= len_q;
      end
   end

   // ************************************************************
   // Word walker over the packet slots
   // ************************************************************
   // Current slot class, enable and length
   always @*
   begin
      cur_cls = slot_cls(slot_q);
      cur_en = snap_ena_q[`IMUF_ITEM_TOP - cur_cls];
      cur_len32 = snap_len_q[`IMUF_ITEM_TOP - cur_cls];
      load = (state_q == ST_SEND) && cur_en
           && (!word_valid_q || word_ready);
      last_word = !cur_len32 || half_q;
   end

   imuf_word_sel u_word (
      .value(snap_q[slot_q*32 +: 32]),
      .len32(cur_len32),
      .half(half_q),
      .word(cur_word)
   );

   // Slot walk: skip disabled items, two words for long ones
   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         state_q <= ST_IDLE;
         slot_q <= 5'd0;
         half_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               slot_q <= 5'd0;
               half_q <= 1'b0;
               if (take_sample)
                  state_q <= ST_SEND;
            end
            ST_SEND:
            begin
               if (!cur_en || (load && last_word))
               begin
                  half_q <= 1'b0;
                  if (slot_q == `IMUF_SLOT_LAST)
                     state_q <= ST_IDLE;
                  else
                     slot_q <= slot_q + 5'd1;
               end
               else if (load)
                  half_q <= 1'b1;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Output word register toward the link serialiser
   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         word_valid_q <= 1'b0;
         word_data_q <= 16'h0000;
      end
      else if (load)
      begin
         word_valid_q <= 1'b1;
         word_data_q <= cur_word;
      end
      else if (word_ready)
         word_valid_q <= 1'b0;
   end

endmodule // imuf_top

// ---- tb/imuf_chk_sva.sv ----
/* Port checker for imuf_top: register shadows, sample path, stream.
   Assumes synchronous active-high srst on clk_sys. */
`include "imuf_map.vh"
module imuf_chk #(
   parameter AW = 12
)(
   input wire clk_sys,
   input wire srst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [AW-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata_q,
   input wire pready,
   input wire pslverr,
   input wire sample_valid,
   input wire sample_ready,
   input wire [31:0] temp_in,
   input wire [95:0] gyro_in,
   input wire [95:0] accel_in,
   input wire [95:0] dlta_in,
   input wire [95:0] dltv_in,
   input wire [127:0] qtn_in,
   input wire [95:0] atti_in,
   input wire [95:0] rate_pol_q,
   input wire [95:0] accel_pol_q,
   input wire accel_range_16g_q,
   input wire [3:0] dlta_shift_q,
   input wire [4:0] dltv_shift_q,
   input wire word_valid_q,
   input wire [15:0] word_data_q,
   input wire word_ready,
   input wire pkt_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   // ******
   // Shadows
   // ******
   logic [15:0] ena_q, len_q, pol_q, rng_q, thi_q;
   wire [7:0] idx = paddr[9:2];
   wire wr = psel && penable && pwrite && pready && paddr[1:0] == 2'b00;
   wire [95:0] gm = {{32{pol_q[4]}}, {32{pol_q[5]}}, {32{pol_q[6]}}};
   wire [95:0] am = {{32{pol_q[1]}}, {32{pol_q[2]}}, {32{pol_q[3]}}};
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   // Track register writes and the taken temperature
   always @(posedge clk_sys)
      if (srst)
         {ena_q, len_q, pol_q, rng_q} <= '0;
      else
      begin
         if (wr && idx == `IMUF_IDX_ENA) ena_q <= pwdata[15:0] & 16'hFF07;
         if (wr && idx == `IMUF_IDX_LEN) len_q <= pwdata[15:0] & 16'h7F00;
         if (wr && idx == `IMUF_IDX_POL) pol_q <= pwdata[15:0] & 16'h007E;
         if (wr && idx == `IMUF_IDX_RNG) rng_q <= pwdata[15:0] & 16'h01FF;
         if (sample_valid && sample_ready) thi_q <= temp_in[31:16];
      end
   a_rate_invert: assert property (
      sample_valid |=> rate_pol_q == ($past(gyro_in) ^ $past(gm)))
      else $error("rate polarity wrong");
   a_accel_invert: assert property (
      sample_valid |=> accel_pol_q == ($past(accel_in) ^ $past(am)))
      else $error("accel polarity wrong");
   a_range_latch: assert property (
      sample_valid |=> accel_range_16g_q == $past(rng_q[8]))
      else $error("range bit wrong");
   a_dlta_code: assert property (
      sample_valid |=> dlta_shift_q == $past(rng_q[7:4]))
      else $error("delta angle code wrong");
   a_dltv_scale: assert property (
      sample_valid |=> dltv_shift_q == $past({1'b0, rng_q[3:0]} + rng_q[8]))
      else $error("delta velocity scale wrong");
   a_word_hold: assert property (
      word_valid_q && !word_ready |=> word_valid_q && $stable(word_data_q))
      else $error("word dropped before accept");
   a_busy_gate: assert property (
      sample_valid && sample_ready |=> pkt_busy && !sample_ready)
      else $error("accepted sample started no packet");
   a_temp_first: assert property (
      sample_valid && sample_ready && ena_q[14] |->
      ##[1:4] word_valid_q && word_data_q == thi_q)
      else $error("temperature word wrong");
   a_len_read: assert property (
      psel && !penable && !pwrite && paddr[9:0] == 10'h038 |=>
      prdata_q == {16'h0000, len_q}) else $error("length readback wrong");
   c_sample: cover property (sample_valid && sample_ready);
   c_stall: cover property (word_valid_q && !word_ready);
   c_err: cover property (psel && penable && pslverr);
endmodule // imuf_chk
bind imuf_top imuf_chk #(.AW(AW)) imuf_chk_i (.*);

// ---- tb/imuf_link_sink.sv ----
/* Link side word sink: takes words on valid and ready, stores them.
   Assumes clk_sys shared; slow makes ready toggle every cycle. */
module imuf_link_sink (
   input wire clk_sys,
   input wire srst,
   input wire slow,
   input wire word_valid_q,
   input wire [15:0] word_data_q,
   output logic word_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [0:255];
   int cnt_q;
   logic ph_q;
   // Accept and store each handed word
   always @(posedge clk_sys)
      if (srst)
      begin
         cnt_q <= 0;
         ph_q <= 1'b0;
         word_ready <= 1'b0;
      end
      else
      begin
         ph_q <= ~ph_q;
         word_ready <= slow ? ph_q : 1'b1;
         if (word_valid_q && word_ready)
         begin
            mem[cnt_q[7:0]] <= word_data_q;
            cnt_q <= cnt_q + 1;
         end
      end
endmodule // imuf_link_sink

// ---- tb/imuf_output_format_config_tb_top.sv ----
/* Bench for imuf_top: APB tasks, sample pulses, stream checks.
   Assumes imuf_link_sink as the link side and the bound checker. */
module imuf_output_format_config_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 0;
   logic srst = 1;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic sample_valid = 0;
   logic slow = 0;
   logic [31:0] temp_in = 32'h1111_0001;
   logic [95:0] gyro_in = {3{32'h2222_0002}};
   logic [95:0] accel_in = {3{32'h3333_0003}};
   logic [95:0] dlta_in = {3{32'h4444_0004}};
   logic [95:0] dltv_in = {3{32'h5555_0005}};
   logic [127:0] qtn_in = {4{32'h6666_0006}};
   logic [95:0] atti_in = {3{32'h7777_0007}};
   wire [31:0] prdata_q;
   wire pready, pslverr, sample_ready, accel_range_16g_q, word_valid_q;
   wire word_ready, pkt_busy;
   wire [95:0] rate_pol_q, accel_pol_q;
   wire [3:0] dlta_shift_q;
   wire [4:0] dltv_shift_q;
   wire [15:0] word_data_q;
   logic [31:0] rd;
   logic er;
   int miscompares = 0;
   int tests_run = 0;
   int cyc = 0;
   int n0, k, l, nw;
   int it [7] = '{1, 3, 3, 3, 3, 4, 3};
   logic [11:0] ra [4] = '{12'h030, 12'h038, 12'h040, 12'h048};
   logic [31:0] mk [4] = '{32'hFF07, 32'h7F00, 32'h007E, 32'h01FF};
   imuf_top #(.AW(12)) imuf_top_i (.*);
   imuf_link_sink imuf_link_sink_i (.*);
   // ******
   // Clock, timeout and tasks
   // ******
   always #12.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         miscompares++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      tests_run++;
      if (g !== e)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic logic [15:0] w(input int i);
      return imuf_link_sink_i.mem[8'(n0 + i)];
   endfunction
   task automatic apb(input logic wr, input logic [11:0] a, input int d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rd = prdata_q;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic pulse();
      @(posedge clk_sys);
      sample_valid <= 1'b1;
      @(posedge clk_sys);
      sample_valid <= 1'b0;
   endtask
   task automatic idle();
      int t = 0;
      repeat (2) @(posedge clk_sys);
      while (pkt_busy !== 1'b0 && t < 500)
      begin
         @(posedge clk_sys);
         t++;
      end
      chk("pkt_busy", 0, pkt_busy);
      repeat (2) @(posedge clk_sys);
   endtask
   // Reset values, masks, unmapped and read-only places
   initial
   begin
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      for (k = 0; k < 4; k++)
      begin
         apb(0, ra[k], 0);
         chk("reset", 0, rd);
         apb(1, ra[k], 32'hFFFF_FFFF);
         apb(0, ra[k], 0);
         chk("mask", mk[k], rd);
         chk("pslverr", 0, er);
      end
      apb(0, 12'h044, 0);
      chk("unmapped err", 1, er);
      chk("unmapped data", 0, rd);
      apb(1, 12'h080, 32'hFFFF);
      apb(0, 12'h080, 0);
      chk("status", 0, rd);
      // All items 32-bit, axes inverted, slow link, refused sample
      slow <= 1'b1;
      n0 = imuf_link_sink_i.cnt_q;
      pulse();
      repeat (4) @(posedge clk_sys);
      chk("sample_ready", 0, sample_ready);
      pulse();
      apb(1, 12'h040, 0);
      idle();
      chk("words", 40, imuf_link_sink_i.cnt_q - n0);
      chk("gyro x", 16'hDDDD, w(2));
      chk("accel z", 16'hFFFC, w(13));
      chk("atti z", 16'h0007, w(39));
      chk("dlta", 4'hF, dlta_shift_q);
      chk("dltv", 5'h10, dltv_shift_q);
      chk("range", 1, accel_range_16g_q);
      chk("accel pol", 32'hCCCC_FFFC, accel_pol_q[95:64]);
      chk("rate pol", 32'hDDDD_FFFD, rate_pol_q[31:0]);
      chk("atti x", 16'h7777, w(34));
      chk("qtn 0", 16'h6666, w(26));
      // Fine range, then each item alone in both lengths
      slow <= 1'b0;
      apb(1, 12'h048, 32'h00A3);
      for (k = 0; k < 7; k++)
         for (l = 0; l < 2; l++)
         begin
            apb(1, 12'h030, 32'h4000 >> k);
            apb(1, 12'h038, l ? 32'h4000 >> k : 0);
            n0 = imuf_link_sink_i.cnt_q;
            nw = it[k] * (l + 1);
            pulse();
            idle();
            chk("count", nw, imuf_link_sink_i.cnt_q - n0);
            chk("first", 16'h1111 * (k + 1), w(0));
            chk("last", l ? k + 1 : 16'h1111 * (k + 1), w(nw - 1));
         end
      chk("dlta", 4'hA, dlta_shift_q);
      chk("dltv", 5'h03, dltv_shift_q);
      chk("range", 0, accel_range_16g_q);
      chk("rate raw", 32'h2222_0002, rate_pol_q[31:0]);
      tally_and_finish();
   end
endmodule // imuf_output_format_config_tb_top
